// ==== logic/capdpw_pkg.sv ====
// Purpose: shared constants and types for the delta capture / aux pwm timer
// Assumes: 32-bit AHB-Lite register port, one clock
// Notes: register indices are word indices, byte address is four times the index
package capdpw_pkg;

  // ==========================================================================
  // register indices (byte address = 4 * index)
  localparam logic [7:0] CAPDPW_IDX_COUNTER = 8'h00;
  localparam logic [7:0] CAPDPW_IDX_PHASE = 8'h04;
  localparam logic [7:0] CAPDPW_IDX_SLOT_ONE = 8'h08;
  localparam logic [7:0] CAPDPW_IDX_SLOT_TWO = 8'h0c;
  localparam logic [7:0] CAPDPW_IDX_SLOT_THREE = 8'h10;
  localparam logic [7:0] CAPDPW_IDX_SLOT_FOUR = 8'h14;
  localparam logic [7:0] CAPDPW_IDX_CTL_ONE = 8'h28;
  localparam logic [7:0] CAPDPW_IDX_CTL_TWO = 8'h2a;

  // ==========================================================================
  // capture control field positions
  localparam int CAPDPW_C1_EDGE_POL_LSB = 0;     // 4 bits, 1 = falling edge
  localparam int CAPDPW_C1_DELTA_RST_LSB = 4;    // 4 bits, 1 = clear counter
  localparam int CAPDPW_C1_LOAD_EN = 8;
  // mode control field positions
  localparam int CAPDPW_C2_SINGLE_RUN = 0;
  localparam int CAPDPW_C2_REARM = 1;            // write 1 action, reads 0
  localparam int CAPDPW_C2_RUN = 4;
  localparam int CAPDPW_C2_SYNC_IN_EN = 5;
  localparam int CAPDPW_C2_SYNC_OUT_SEL_LSB = 6; // 2 bits
  localparam int CAPDPW_C2_FORCE_LOAD = 8;       // write 1 action, reads 0
  localparam int CAPDPW_C2_PWM_MODE = 9;
  localparam int CAPDPW_C2_ACTIVE_LOW = 10;
  localparam int CAPDPW_C2_SEQ_LSB = 12;         // 2 bits, read only
  localparam int CAPDPW_C2_STOPPED = 14;         // read only

  // ==========================================================================
  // reset values and encodings
  localparam logic [31:0] CAPDPW_WORD_RESET = 32'h0000_0000;
  localparam logic [1:0] CAPDPW_SEQ_LAST = 2'h3;

  typedef enum logic [1:0] {
    CAPDPW_SYNC_OUT_PULSE_PASS = 2'h0,
    CAPDPW_SYNC_OUT_PULSE_PERIOD = 2'h1,
    CAPDPW_SYNC_OUT_PULSE_OFF = 2'h2
  } capdpw_sync_out_pulse_e;

  // ==========================================================================
  // complete state of the timer
  typedef struct packed {
    logic [31:0] timestamp_counter;
    logic [31:0] phase_preload_value;
    logic [3:0][31:0] slot;              // capture slots one to four
    logic [3:0] edge_polarity;
    logic [3:0] delta_reset;
    logic capture_load_enable;
    logic continuous_or_single_run;
    logic counter_run_control;
    logic sync_input_enable;
    logic [1:0] sync_output_select;
    logic capture_or_pwm_select;
    logic aux_output_polarity;
    logic [1:0] event_sequencer;
    logic stopped;
    logic [2:0] pin_sync;                // capture pin synchroniser chain
    logic pin_level;                     // debounced pin level
    logic aux_pwm;
    logic sync_out;
    logic bus_pending;                   // write data phase outstanding
    logic [7:0] bus_index;
    logic [31:0] rdata;
  } capdpw_state_s;

endpackage

// ==== logic/capdpw_top.sv ====
// Purpose: delta-time capture and auxiliary pwm timer with AHB-Lite registers
// Assumes: single clock hclk at 100 MHz, sync pulses from siblings on hclk
// Notes: zero-wait-state slave, every response OKAY
// Function
// R01: each of four events qualifies on its own rising or falling edge select
// R02: pwm mode writes to slots one or two also copy into slots three or four
// R03: software initialises active period/compare, then updates only the shadows
// R04: pwm mode drives the pwm pin, slot two is the compare value
// R05: active low polarity inverts the pwm output
// R06: period-match sync select pulses sync out when counter reaches period
// R07: enabled sync input realigns the counter to the master
// R08: sync in or software force loads the phase preload into the counter
// R09: pwm mode uses slot one as period, slot two as compare
// R10: delta event stores the counter into the slot, then clears the counter
// R11: pwm counter runs zero to period, output active while below compare
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module capdpw_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic capture_pin,
  input wire logic sync_in_pulse,
  output logic sync_out_pulse,
  output logic aux_pwm_output_pin
);

  capdpw_pkg::capdpw_state_s st_reg;
  capdpw_pkg::capdpw_state_s st_next;
  logic addr_take;
  logic write_now;
  logic [31:0] wd;
  logic [31:0] period_val;
  logic period_hit;
  logic edge_rise;
  logic edge_fall;
  logic event_valid;
  logic phase_load;
  logic force_now;
  logic rearm_now;

  // all-zero word for counter clears and unmapped reads
  localparam logic [31:0] CAPDPW_ZERO = capdpw_pkg::CAPDPW_WORD_RESET;

  // ==========================================================================
  // bus decode: only whole-word transfers are accepted
  assign addr_take = hsel && htrans[1] && hready && (hsize == 3'h2);
  assign write_now = st_reg.bus_pending;
  assign wd = hwdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_reg.rdata;
  assign sync_out_pulse = st_reg.sync_out;
  assign aux_pwm_output_pin = st_reg.aux_pwm;

  // ==========================================================================
  // shared terms of the counter logic
  assign period_val = st_reg.slot[0];                                // [R09]
  assign period_hit = st_reg.capture_or_pwm_select && st_reg.counter_run_control
    && (st_reg.timestamp_counter == period_val);
  assign edge_rise = (st_reg.pin_sync[1] == st_reg.pin_sync[2]) && st_reg.pin_sync[2]
    && !st_reg.pin_level;
  assign edge_fall = (st_reg.pin_sync[1] == st_reg.pin_sync[2]) && !st_reg.pin_sync[2]
    && st_reg.pin_level;
  // event qualified by the edge select of the current sequencer slot
  assign event_valid = !st_reg.capture_or_pwm_select && st_reg.counter_run_control
    && !st_reg.stopped
    && (st_reg.edge_polarity[st_reg.event_sequencer] ? edge_fall : edge_rise); // [R01]
  assign force_now = write_now && (st_reg.bus_index == capdpw_pkg::CAPDPW_IDX_CTL_TWO)
    && wd[capdpw_pkg::CAPDPW_C2_FORCE_LOAD];
  assign rearm_now = write_now && (st_reg.bus_index == capdpw_pkg::CAPDPW_IDX_CTL_TWO)
    && wd[capdpw_pkg::CAPDPW_C2_REARM];
  assign phase_load = (st_reg.sync_input_enable && sync_in_pulse) || force_now; // [R07] [R08]

  // ==========================================================================
  // next-state logic
  always_comb begin
    st_next = st_reg;
    // capture pin synchroniser, a change counts once stages two and three agree
    st_next.pin_sync = {st_reg.pin_sync[1:0], capture_pin};
    if (st_reg.pin_sync[1] == st_reg.pin_sync[2]) begin
      st_next.pin_level = st_reg.pin_sync[2];
    end

    // counter: run, wrap at period in pwm mode, delta clear on events
    if (st_reg.counter_run_control) begin
      if (period_hit) begin
        st_next.timestamp_counter = CAPDPW_ZERO;                     // [R11]
      end else begin
        st_next.timestamp_counter = st_reg.timestamp_counter + 32'h0000_0001;
      end
    end
    if (period_hit) begin
      // shadow values move into the active slots at the period boundary
      st_next.slot[0] = st_reg.slot[2];
      st_next.slot[1] = st_reg.slot[3];
    end

    // rearm clears the stop; an event in the same cycle still stops and advances
    if (rearm_now) begin
      st_next.stopped = 1'b0;
      st_next.event_sequencer = 2'h0;
    end

    // capture event: store first, then clear in delta mode, then advance
    if (event_valid) begin
      if (st_reg.capture_load_enable) begin
        st_next.slot[st_reg.event_sequencer] = st_reg.timestamp_counter; // [R10]
      end
      if (st_reg.delta_reset[st_reg.event_sequencer]) begin
        st_next.timestamp_counter = CAPDPW_ZERO;                     // [R10]
      end
      st_next.event_sequencer = st_reg.event_sequencer + 2'h1;
      if (st_reg.continuous_or_single_run
          && (st_reg.event_sequencer == capdpw_pkg::CAPDPW_SEQ_LAST)) begin
        st_next.stopped = 1'b1;
      end
    end

    // sync in or software force loads the phase preload
    if (phase_load) begin
      st_next.timestamp_counter = st_reg.phase_preload_value;        // [R07] [R08]
    end
    // register writes in the data phase; software writes win over hardware
    if (write_now) begin
      case (st_reg.bus_index)
        capdpw_pkg::CAPDPW_IDX_COUNTER: begin
          st_next.timestamp_counter = wd;
        end
        capdpw_pkg::CAPDPW_IDX_PHASE: begin
          st_next.phase_preload_value = wd;
        end
        capdpw_pkg::CAPDPW_IDX_SLOT_ONE: begin
          st_next.slot[0] = wd;
          if (st_reg.capture_or_pwm_select) begin
            st_next.slot[2] = wd;                                    // [R02]
          end
        end
        capdpw_pkg::CAPDPW_IDX_SLOT_TWO: begin
          st_next.slot[1] = wd;
          if (st_reg.capture_or_pwm_select) begin
            st_next.slot[3] = wd;                                    // [R02]
          end
        end
        capdpw_pkg::CAPDPW_IDX_SLOT_THREE: begin
          st_next.slot[2] = wd;
        end
        capdpw_pkg::CAPDPW_IDX_SLOT_FOUR: begin
          st_next.slot[3] = wd;
        end
        capdpw_pkg::CAPDPW_IDX_CTL_ONE: begin
          st_next.edge_polarity = wd[capdpw_pkg::CAPDPW_C1_EDGE_POL_LSB +: 4];
          st_next.delta_reset = wd[capdpw_pkg::CAPDPW_C1_DELTA_RST_LSB +: 4];
          st_next.capture_load_enable = wd[capdpw_pkg::CAPDPW_C1_LOAD_EN];
        end
        capdpw_pkg::CAPDPW_IDX_CTL_TWO: begin
          st_next.continuous_or_single_run = wd[capdpw_pkg::CAPDPW_C2_SINGLE_RUN];
          st_next.counter_run_control = wd[capdpw_pkg::CAPDPW_C2_RUN];
          st_next.sync_input_enable = wd[capdpw_pkg::CAPDPW_C2_SYNC_IN_EN];
          st_next.sync_output_select = wd[capdpw_pkg::CAPDPW_C2_SYNC_OUT_SEL_LSB +: 2];
          st_next.capture_or_pwm_select = wd[capdpw_pkg::CAPDPW_C2_PWM_MODE];
          st_next.aux_output_polarity = wd[capdpw_pkg::CAPDPW_C2_ACTIVE_LOW];
        end
        default: begin
        end
      endcase
    end

    // pwm pin: active while counter below compare, inverted for active low
    if (st_reg.capture_or_pwm_select) begin
      st_next.aux_pwm = (st_next.timestamp_counter < st_next.slot[1])
        ^ st_next.aux_output_polarity;                               // [R04] [R05] [R11]
    end else begin
      st_next.aux_pwm = 1'b0;
    end

    // sync out: pass-through, period match or off
    case (st_reg.sync_output_select)
      capdpw_pkg::CAPDPW_SYNC_OUT_PULSE_PASS: begin
        st_next.sync_out = sync_in_pulse;
      end
      capdpw_pkg::CAPDPW_SYNC_OUT_PULSE_PERIOD: begin
        st_next.sync_out = period_hit;                               // [R06]
      end
      default: begin
        st_next.sync_out = 1'b0;
      end
    endcase

    // address phase: latch write target, or load read data from the next state
    st_next.bus_pending = addr_take && hwrite;
    st_next.bus_index = haddr[9:2];
    if (addr_take && !hwrite) begin
      st_next.rdata = read_word(st_next, haddr[9:2]);
    end
  end

  // ==========================================================================
  // read multiplexer, unmapped words read zero
  function automatic logic [31:0] read_word(input capdpw_pkg::capdpw_state_s s,
                                            input logic [7:0] idx);
    logic [31:0] v;
    v = CAPDPW_ZERO;
    case (idx)
      capdpw_pkg::CAPDPW_IDX_COUNTER: v = s.timestamp_counter;
      capdpw_pkg::CAPDPW_IDX_PHASE: v = s.phase_preload_value;
      capdpw_pkg::CAPDPW_IDX_SLOT_ONE: v = s.slot[0];
      capdpw_pkg::CAPDPW_IDX_SLOT_TWO: v = s.slot[1];
      capdpw_pkg::CAPDPW_IDX_SLOT_THREE: v = s.slot[2];
      capdpw_pkg::CAPDPW_IDX_SLOT_FOUR: v = s.slot[3];
      capdpw_pkg::CAPDPW_IDX_CTL_ONE: begin
        v[capdpw_pkg::CAPDPW_C1_EDGE_POL_LSB +: 4] = s.edge_polarity;
        v[capdpw_pkg::CAPDPW_C1_DELTA_RST_LSB +: 4] = s.delta_reset;
        v[capdpw_pkg::CAPDPW_C1_LOAD_EN] = s.capture_load_enable;
      end
      capdpw_pkg::CAPDPW_IDX_CTL_TWO: begin
        v[capdpw_pkg::CAPDPW_C2_SINGLE_RUN] = s.continuous_or_single_run;
        v[capdpw_pkg::CAPDPW_C2_RUN] = s.counter_run_control;
        v[capdpw_pkg::CAPDPW_C2_SYNC_IN_EN] = s.sync_input_enable;
        v[capdpw_pkg::CAPDPW_C2_SYNC_OUT_SEL_LSB +: 2] = s.sync_output_select;
        v[capdpw_pkg::CAPDPW_C2_PWM_MODE] = s.capture_or_pwm_select;
        v[capdpw_pkg::CAPDPW_C2_ACTIVE_LOW] = s.aux_output_polarity;
        v[capdpw_pkg::CAPDPW_C2_SEQ_LSB +: 2] = s.event_sequencer;
        v[capdpw_pkg::CAPDPW_C2_STOPPED] = s.stopped;
      end
      default: v = CAPDPW_ZERO;
    endcase
    return v;
  endfunction

  // ==========================================================================
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule // capdpw_top

// ==== verification/capdpw_src.sv ====
// Purpose: far-side model, a pulse source on the capture pin and a sync master
// Assumes: driven on hclk rising edges, tasks entered just after an edge
// Notes: sync pulse is one cycle wide, as the master's period match gives
`timescale 1ns/1ps
module capdpw_src (
  input wire logic hclk,
  output logic capture_pin,
  output logic sync_in_pulse
);
  initial begin
    capture_pin = 1'b0;
    sync_in_pulse = 1'b0;
  end
  // one high phase of hi cycles, then a low phase of lo cycles
  task automatic pulse(input int hi, input int lo);
    capture_pin <= 1'b1;
    repeat (hi) @(posedge hclk);
    capture_pin <= 1'b0;
    repeat (lo) @(posedge hclk);
  endtask
  // one-cycle sync pulse from the master
  task automatic sync();
    sync_in_pulse <= 1'b1;
    @(posedge hclk);
    sync_in_pulse <= 1'b0;
  endtask
endmodule // capdpw_src

// ==== verification/capdpw_sva.sv ====
// Purpose: port checks of the capture / aux pwm timer
// Assumes: pwm tests keep compare between 1 and the period, period above 0
// Notes: mode bits are followed from bus writes to control two
`timescale 1ns/1ps
module capdpw_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic capture_pin,
  input wire logic sync_in_pulse,
  input wire logic sync_out_pulse,
  input wire logic aux_pwm_output_pin
);
  // ==========================================================================
  // copy of control two, taken at the end of a write data phase
  logic pend_reg;
  logic [31:0] ctl2_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= 1'b0;
      ctl2_reg <= 32'h0000_0000;
    end else begin
      pend_reg <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2 &&
        haddr[9:2] == capdpw_pkg::CAPDPW_IDX_CTL_TWO;
      if (pend_reg) ctl2_reg <= hwdata;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================================
  // assertions
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus wait or error");
  a_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite && hsize == 3'h2)
    |=> $stable(hrdata)) else $error("read data moved");
  a_sync_pass: assert property (ctl2_reg[7:6] == 2'h0 |=>
    sync_out_pulse == $past(sync_in_pulse)) else $error("sync not passed on");
  a_sync_off: assert property (ctl2_reg[7] |=> !sync_out_pulse)
    else $error("sync out while off");
  a_cap_quiet: assert property (ctl2_reg[7:6] == 2'h1 && !ctl2_reg[9] |=>
    !sync_out_pulse) else $error("period sync in capture mode");
  a_sync_single: assert property (ctl2_reg[7:6] == 2'h1 && sync_out_pulse |=>
    !sync_out_pulse) else $error("sync pulse too long");
  a_pwm_idle: assert property (!ctl2_reg[9] |=> !aux_pwm_output_pin)
    else $error("pwm pin active in capture mode");
  a_pwm_wrap: assert property (ctl2_reg[7:6] == 2'h1 && ctl2_reg[9] && sync_out_pulse &&
    ctl2_reg == $past(ctl2_reg, 2) |-> aux_pwm_output_pin != ctl2_reg[10] &&
    $past(aux_pwm_output_pin) == ctl2_reg[10]) else $error("pwm level wrong at wrap");
endmodule // capdpw_sva
bind capdpw_top capdpw_sva chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .capture_pin, .sync_in_pulse,
  .sync_out_pulse, .aux_pwm_output_pin);

// ==== verification/capdpw_top_tb.sv ====
// Purpose: self-checking bench of the capture / aux pwm timer
// Assumes: zero-wait slave, hready fed from hreadyout
// Notes: register model kept in an associative array
`timescale 1ns/1ps
module capdpw_top_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, s[4];
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, capture_pin, sync_in_pulse, sync_out_pulse, aux_pwm_output_pin;
  logic [31:0] mdl [logic [7:0]];
  logic pwm = 1'b0;
  int bad_count = 0, num_checks = 0, h, l, p, c, n, hi, seed;
  capdpw_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .capture_pin, .sync_in_pulse,
    .sync_out_pulse, .aux_pwm_output_pin);
  capdpw_src src (.hclk, .capture_pin, .sync_in_pulse);
  always #5 hclk = ~hclk;
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one AHB single transfer, model follows writes
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    if (wr && idx == capdpw_pkg::CAPDPW_IDX_CTL_TWO) pwm = d[9];
    if (wr && idx inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h28}) mdl[idx] = d;
    if (wr && pwm && idx inside {8'h08, 8'h0c}) mdl[idx + 8'h08] = d;
  endtask
  // read and compare with the model
  task automatic rdc(input logic [7:0] idx);
    bus(idx, 1'b0, 32'h0);
    chk(q, mdl.exists(idx) ? mdl[idx] : 32'h0);
  endtask
  // one pwm period between sync pulses: length and high cycles
  task automatic measure();
    n = 0;
    hi = 0;
    @(negedge hclk);
    while (sync_out_pulse !== 1'b1 && n < 900) begin
      n++;
      @(negedge hclk);
    end
    n = 0;
    do begin
      n++;
      hi += int'(aux_pwm_output_pin === 1'b1);
      @(negedge hclk);
    end while (sync_out_pulse !== 1'b1 && n < 900);
    // hand back just after a rising edge, where the next bus call may start
    @(posedge hclk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #300000;
    bad_count++;
    $display("Error %0t: watchdog", $time);
    test_done();
  end
  initial begin
    seed = $urandom(71);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++) rdc(8'(capdpw_pkg::CAPDPW_IDX_COUNTER + 4 * i));
    bus(8'h3f, 1'b1, 32'hffff_ffff);
    rdc(8'h3f);
    $display("reset and map test done");
    // delta capture, rise and fall alternating, all events clear
    // three pulses give six events, so slot one is rewritten with a low time
    bus(capdpw_pkg::CAPDPW_IDX_CTL_ONE, 1'b1, 32'h0000_01fa);
    bus(capdpw_pkg::CAPDPW_IDX_CTL_TWO, 1'b1, 32'h0000_0050);
    h = 8 + $urandom % 32;
    l = 8 + $urandom % 32;
    repeat (3) src.pulse(h, l);
    for (int i = 0; i < 4; i++) begin
      bus(8'(capdpw_pkg::CAPDPW_IDX_SLOT_ONE + 4 * i), 1'b0, 32'h0);
      s[i] = q;
    end
    chk(s[3], s[1]);
    chk(s[2] - s[1], 32'(l - h));
    chk(s[0], s[2]);
    chk(32'(int'(32'(h) - s[1] <= 2)), 32'h1);
    bus(capdpw_pkg::CAPDPW_IDX_CTL_TWO, 1'b0, 32'h0);
    chk(32'(q[13:12]), 32'h2);
    $display("delta capture test done");
    // single run: rearm, stop after the fourth event, the third pulse is ignored
    bus(capdpw_pkg::CAPDPW_IDX_CTL_TWO, 1'b1, 32'h0000_0013);
    repeat (2) src.pulse(h, l);
    src.pulse(h + 5, l);
    bus(capdpw_pkg::CAPDPW_IDX_SLOT_TWO, 1'b0, 32'h0);
    chk(q, 32'(h - 1));
    bus(capdpw_pkg::CAPDPW_IDX_CTL_TWO, 1'b0, 32'h0);
    chk(32'(q[14:12]), 32'h4);
    $display("single run test done");
    // pwm: init actives, then shadow update
    p = 20 + $urandom % 30;
    c = 1 + $urandom % p;
    bus(capdpw_pkg::CAPDPW_IDX_SLOT_ONE, 1'b1, 32'(p));
    bus(capdpw_pkg::CAPDPW_IDX_COUNTER, 1'b1, 32'h0);
    bus(capdpw_pkg::CAPDPW_IDX_CTL_TWO, 1'b1, 32'h0000_0250);
    bus(capdpw_pkg::CAPDPW_IDX_SLOT_ONE, 1'b1, 32'(p));
    bus(capdpw_pkg::CAPDPW_IDX_SLOT_TWO, 1'b1, 32'(c));
    rdc(capdpw_pkg::CAPDPW_IDX_SLOT_THREE);
    rdc(capdpw_pkg::CAPDPW_IDX_SLOT_FOUR);
    measure();
    chk(32'(n), 32'(p + 1));
    chk(32'(hi), 32'(c));
    bus(capdpw_pkg::CAPDPW_IDX_CTL_TWO, 1'b1, 32'h0000_0650);
    measure();
    chk(32'(n - hi), 32'(c));
    c = 1 + $urandom % p;
    bus(capdpw_pkg::CAPDPW_IDX_SLOT_FOUR, 1'b1, 32'(c));
    measure();
    chk(32'(n - hi), 32'(c));
    $display("pwm test done");
    // phase preload by sync in, then by software force with sync out off
    h = $urandom % 32'h0100_0000;
    bus(capdpw_pkg::CAPDPW_IDX_PHASE, 1'b1, 32'(h));
    bus(capdpw_pkg::CAPDPW_IDX_CTL_TWO, 1'b1, 32'h0000_0030);
    src.sync();
    bus(capdpw_pkg::CAPDPW_IDX_COUNTER, 1'b0, 32'h0);
    chk(32'(int'(q - 32'(h) <= 4)), 32'h1);
    h = $urandom % 32'h0100_0000;
    bus(capdpw_pkg::CAPDPW_IDX_PHASE, 1'b1, 32'(h));
    bus(capdpw_pkg::CAPDPW_IDX_CTL_TWO, 1'b1, 32'h0000_01b0);
    bus(capdpw_pkg::CAPDPW_IDX_COUNTER, 1'b0, 32'h0);
    chk(32'(int'(q - 32'(h) <= 4)), 32'h1);
    $display("sync and phase test done");
    test_done();
  end
endmodule // capdpw_top_tb
